// ==== logic/exd_dispatch.sv ====
// Exception recognition and dispatch for a 32-bit core.
// Assumes the completion stage presents instructions oldest first and holds
// each report until o_cmp_ready; pins arrive asynchronously.
`timescale 1ns/1ps
module exd_dispatch
    import exd_pkg::*;
#(
    parameter bit ALIGN_TRAP = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cmp_valid,
    input  wire exd_cmp_t    i_cmp,
    output logic             o_cmp_ready,
    input  wire logic        i_exec_busy,
    input  wire logic [31:0] i_next_pc,
    input  wire logic        i_dec_msb,
    input  wire logic        i_reset_req,
    input  wire logic        i_mcheck_req,
    input  wire logic        i_ext_req,
    input  wire logic        i_state_lost,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    output logic             o_take,
    output logic [31:0]      o_vector,
    output exd_cause_t       o_cause,
    output logic             o_checkstop
);

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_STOP = 2'b10
    } exd_state_t;

    function automatic logic [19:0] vec_off(input exd_cause_t c);
        case (c)
            C_RESET:   vec_off = OFF_RESET;
            C_MCHECK:  vec_off = OFF_MCHECK;
            C_DSTORE:  vec_off = OFF_DSTORE;
            C_ISTORE:  vec_off = OFF_ISTORE;
            C_EXTERN:  vec_off = OFF_EXTERN;
            C_ALIGN:   vec_off = OFF_ALIGN;
            C_PROGRAM: vec_off = OFF_PROGRAM;
            C_FPUNAV:  vec_off = OFF_FPUNAV;
            C_DECR:    vec_off = OFF_DECR;
            C_SYSCALL: vec_off = OFF_SYSCALL;
            C_TRACE:   vec_off = OFF_TRACE;
            C_FPASST:  vec_off = OFF_FPASST;
            default:   vec_off = OFF_RESET;
        endcase
    endfunction : vec_off

    function automatic exd_cause_t sync_cause(input int idx);
        case (idx)
            S_ISI:   sync_cause = C_ISTORE;
            S_FPU:   sync_cause = C_FPUNAV;
            S_ALN:   sync_cause = C_ALIGN;
            S_DSI:   sync_cause = C_DSTORE;
            S_SC:    sync_cause = C_SYSCALL;
            S_TRC:   sync_cause = C_TRACE;
            S_AST:   sync_cause = C_FPASST;
            default: sync_cause = C_PROGRAM;
        endcase
    endfunction : sync_cause

    // Reset, machine check and external pins cross into the core clock through two flops each; i_state_lost is not synchronised.
    logic [2:0] pin_raw;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    assign pin_raw = {i_ext_req, i_mcheck_req, i_reset_req};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    pin_meta[g] <= 1'b0;
                    pin_sync[g] <= 1'b0;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    logic ext_pend;
    logic mck_pend;
    logic rst_pend;
    assign rst_pend = pin_sync[0];
    assign mck_pend = pin_sync[1];
    assign ext_pend = pin_sync[2];

    exd_state_t        state;
    exd_state_t        next_state;
    logic [31:0]       msw;
    logic [31:0]       next_msw;
    logic [31:0]       ras;
    logic [31:0]       next_ras;
    logic [31:0]       sms;
    logic [31:0]       next_sms;
    logic              dec_prev;
    logic              dec_pend;
    logic              next_dec_pend;
    logic              rst_prev;
    logic              mck_prev;
    logic [NSYNC-1:0]  mask;
    logic [NSYNC-1:0]  next_mask;
    logic              loaded;
    logic              next_loaded;
    logic [NSYNC-1:0]  raw;
    logic [NSYNC-1:0]  cur;
    logic              take;
    exd_cause_t        cause;
    logic [31:0]       save_pc;
    logic [31:0]       next_vector;
    logic              next_take;
    exd_cause_t        next_cause;
    logic [31:0]       vector;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;

    // Conditions of the oldest instruction; privilege, FPU, float, alignment and trace ones gated by their enables.
    always_comb begin
        raw        = '0;
        raw[S_ISI] = i_cmp.fetch_fault;
        raw[S_ILL] = i_cmp.illegal_op;
        raw[S_PRV] = msw[MSW_PR] & (i_cmp.privileged
                     | i_cmp.spr_invalid_hi);
        raw[S_FPU] = i_cmp.float_op & ~msw[MSW_FP];
        raw[S_FEX] = (msw[MSW_FE0] | msw[MSW_FE1])
                     & i_cmp.float_enabled_summary;
        raw[S_TRP] = i_cmp.trap_hit;
        raw[S_ALN] = ALIGN_TRAP & i_cmp.misaligned;
        raw[S_DSI] = i_cmp.data_fault;
        raw[S_SC]  = i_cmp.system_call_instr;
        raw[S_TRC] = msw[MSW_SE]
                     | (msw[MSW_BE] & i_cmp.branch);
        raw[S_AST] = i_cmp.float_assist;
        if (!i_cmp_valid) begin
            raw = '0;
        end
    end

    // One condition leaves per cycle; the instruction retires when none
    // remain, so a later instruction can never overtake it.
    always_comb begin
        cur         = loaded ? mask : raw;
        next_mask   = cur;
        next_loaded = loaded;
        take        = 1'b0;
        cause       = C_NONE;
        save_pc     = i_next_pc;
        o_cmp_ready = 1'b0;
        next_dec_pend = dec_pend | (i_dec_msb & ~dec_prev);
        // Reset is looked at first, since only it can lift a checkstop.
        if (rst_pend & ~rst_prev) begin
            take  = 1'b1;
            cause = C_RESET;
        end else if (state == ST_STOP) begin
            o_cmp_ready = 1'b0;
        end else if (mck_pend & ~mck_prev & msw[MSW_ME]) begin
            take  = 1'b1;
            cause = C_MCHECK;
        end else if (i_cmp_valid && cur != '0) begin
            take        = 1'b1;
            next_loaded = 1'b1;
            save_pc     = i_cmp.pc;
            for (int k = NSYNC - 1; k >= 0; k--) begin
                if (cur[k]) begin
                    cause = sync_cause(k);
                end
            end
            for (int k = 0; k < NSYNC; k++) begin
                if (cur[k] && cause == sync_cause(k)
                    && (cur & ((11'h001 << k) - 11'h001)) == '0) begin
                    next_mask[k] = 1'b0;
                end
            end
            if (cause == C_SYSCALL || cause == C_TRACE) begin
                save_pc = i_cmp.next_pc;
            end
        end else if (i_cmp_valid) begin
            // The mask stays loaded, though empty, until retirement, so the
            // report's flags are never decoded a second time.
            o_cmp_ready = 1'b1;
            next_loaded = 1'b0;
        end else if (!i_exec_busy && ext_pend && msw[MSW_EE]) begin
            take  = 1'b1;
            cause = C_EXTERN;
        end else if (!i_exec_busy && dec_pend && msw[MSW_EE]) begin
            take          = 1'b1;
            cause         = C_DECR;
            next_dec_pend = i_dec_msb & ~dec_prev;
        end
    end

    // Software writes the state word; a hardware take in the same cycle wins.
    always_comb begin
        next_state  = state;
        next_msw    = msw;
        next_ras    = ras;
        next_sms    = sms;
        next_take   = take;
        next_cause  = cause;
        next_vector = vector;
        next_rdata  = 32'h0000_0000;
        if (i_wr) begin
            case (i_addr)
                REG_MSW: next_msw = i_wdata;
                REG_RAS: next_ras = i_wdata;
                REG_SMS: next_sms = i_wdata;
                default: next_msw = msw;
            endcase
        end
        if (state == ST_RUN && mck_pend && !mck_prev && !msw[MSW_ME]
            && !(rst_pend && !rst_prev)) begin
            next_state = ST_STOP;
        end
        if (take) begin
            next_ras = save_pc;
            next_sms = msw;
            if ((cause == C_RESET || cause == C_MCHECK) && i_state_lost) begin
                next_sms[MSW_RI] = 1'b0;
            end
            next_msw         = msw;
            next_msw[MSW_PR] = 1'b0;
            next_msw[MSW_EE] = 1'b0;
            next_msw[MSW_SE] = 1'b0;
            next_msw[MSW_BE] = 1'b0;
            next_msw[MSW_RI] = 1'b0;
            next_vector = {12'h000, vec_off(cause)}
                          | (msw[MSW_IP] ? VEC_HIGH_BASE
                                         : 32'h0000_0000);
        end
        if (cause == C_RESET) begin
            next_state = ST_RUN;
        end
        if (i_rd) begin
            case (i_addr)
                REG_MSW:    next_rdata = msw;
                REG_RAS:    next_rdata = ras;
                REG_SMS:    next_rdata = sms;
                REG_STATUS: next_rdata = {26'h0, loaded,
                                          dec_pend, ext_pend, mck_pend,
                                          rst_pend, state == ST_STOP};
                default:    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state    <= ST_RUN;
            msw      <= MSW_RST;
            ras      <= 32'h0000_0000;
            sms      <= 32'h0000_0000;
            dec_prev <= 1'b0;
            dec_pend <= 1'b0;
            rst_prev <= 1'b0;
            mck_prev <= 1'b0;
            mask     <= '0;
            loaded   <= 1'b0;
            o_take   <= 1'b0;
            o_cause  <= C_NONE;
            vector   <= 32'h0000_0000;
            rdata    <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            msw      <= next_msw;
            ras      <= next_ras;
            sms      <= next_sms;
            dec_prev <= i_dec_msb;
            dec_pend <= next_dec_pend;
            rst_prev <= rst_pend;
            mck_prev <= mck_pend;
            mask     <= next_mask;
            loaded   <= next_loaded;
            o_take   <= next_take;
            o_cause  <= next_cause;
            vector   <= next_vector;
            rdata    <= next_rdata;
        end
    end

    assign o_vector    = vector;
    assign o_rdata     = rdata;
    assign o_checkstop = state == ST_STOP;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_ext_ready;
        ext_pend && msw[MSW_EE] && !i_exec_busy && !i_cmp_valid;
    endsequence

    sequence s_quiet;
        state == ST_RUN && !(rst_pend && !rst_prev)
        && !(mck_pend && !mck_prev);
    endsequence

    chk_ext_gate: assert property (
        take && cause == C_EXTERN |-> msw[MSW_EE] && ext_pend)
        else $error("external taken while masked or idle");
    chk_ext_busy: assert property (
        s_quiet and s_ext_ready and (!dec_pend) |-> ##1 o_take
        && o_cause == C_EXTERN)
        else $error("enabled external request not taken");
    chk_async_wait: assert property (
        take && (cause == C_EXTERN || cause == C_DECR) |-> !i_exec_busy)
        else $error("async exception taken during execute");
    chk_vec_place: assert property (
        take |=> o_vector[19:0] == vec_off(o_cause)
        && o_vector[31:20] == ($past(msw[MSW_IP]) ? 12'hfff : 12'h000))
        else $error("vector address wrong");
    chk_vec_rsvd: assert property (
        o_take |-> o_vector[19:0] != OFF_RSV_A
        && o_vector[19:0] != OFF_RSV_B
        && !(o_vector[19:0] >= OFF_RSV_LO && o_vector[19:0] <= OFF_RSV_HI))
        else $error("reserved vector used");
    chk_super_mode: assert property (
        o_take |-> !msw[MSW_PR] && !msw[MSW_EE])
        else $error("take did not enter supervisor mode");
    chk_save_pair: assert property (
        take && !$past(take) |=> sms == $past(msw, 1) || !sms[MSW_RI])
        else $error("state not saved with return address");
    chk_ret_next: assert property (
        take && cause == C_DECR |=> ras == $past(i_next_pc))
        else $error("decrementer return address wrong");
    chk_dec_edge: assert property (
        !i_dec_msb ##1 i_dec_msb
        |=> dec_pend || $past(take && cause == C_DECR))
        else $error("decrementer edge lost");
    chk_mck_stop: assert property (
        state == ST_RUN && !(rst_pend && !rst_prev) && mck_pend && !mck_prev
        && !msw[MSW_ME] |=> o_checkstop)
        else $error("disabled machine check did not stop");
    chk_retire_clear: assert property (
        o_cmp_ready |-> i_cmp_valid && !take && (loaded ? mask : raw) == '0)
        else $error("instruction retired with exception left");
    chk_one_each: assert property (
        take && loaded && cause != C_RESET && cause != C_MCHECK
        |-> $countones(next_mask) == $countones(mask) - 1)
        else $error("conditions merged");
    chk_sc_vec: assert property (
        take && cause == C_SYSCALL |=> o_vector[19:0] == OFF_SYSCALL
        && ras == $past(i_cmp.next_pc))
        else $error("system call dispatch wrong");

endmodule : exd_dispatch

// ==== logic/exd_pkg.sv ====
// Package for the exception dispatch unit: cause codes, vector offsets,
// machine state word layout, register offsets and the completion report.
// Assumes a single 25 MHz core clock shared by every user of the package.
package exd_pkg;

    localparam logic [19:0] OFF_RESET   = 20'h00100;
    localparam logic [19:0] OFF_MCHECK  = 20'h00200;
    localparam logic [19:0] OFF_DSTORE  = 20'h00300;
    localparam logic [19:0] OFF_ISTORE  = 20'h00400;
    localparam logic [19:0] OFF_EXTERN  = 20'h00500;
    localparam logic [19:0] OFF_ALIGN   = 20'h00600;
    localparam logic [19:0] OFF_PROGRAM = 20'h00700;
    localparam logic [19:0] OFF_FPUNAV  = 20'h00800;
    localparam logic [19:0] OFF_DECR    = 20'h00900;
    localparam logic [19:0] OFF_RSV_A   = 20'h00a00;
    localparam logic [19:0] OFF_RSV_B   = 20'h00b00;
    localparam logic [19:0] OFF_SYSCALL = 20'h00c00;
    localparam logic [19:0] OFF_TRACE   = 20'h00d00;
    localparam logic [19:0] OFF_FPASST  = 20'h00e00;
    localparam logic [19:0] OFF_RSV_LO  = 20'h00e10;
    localparam logic [19:0] OFF_RSV_HI  = 20'h02fff;

    // Base used when the vector prefix select bit is set; value arbitrary.
    localparam logic [31:0] VEC_HIGH_BASE = 32'hfff0_0000;

    localparam int MSW_RI  = 0;
    localparam int MSW_EE  = 1;
    localparam int MSW_PR  = 2;
    localparam int MSW_FP  = 3;
    localparam int MSW_ME  = 4;
    localparam int MSW_SE  = 5;
    localparam int MSW_BE  = 6;
    localparam int MSW_IP  = 7;
    localparam int MSW_FE0 = 8;
    localparam int MSW_FE1 = 9;
    localparam logic [31:0] MSW_RST = 32'h0000_0010;

    localparam logic [3:0] REG_MSW    = 4'h0;
    localparam logic [3:0] REG_RAS    = 4'h4;
    localparam logic [3:0] REG_SMS    = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // Program-order priority of conditions raised by one instruction.
    localparam int NSYNC = 11;
    localparam int S_ISI = 0;
    localparam int S_ILL = 1;
    localparam int S_PRV = 2;
    localparam int S_FPU = 3;
    localparam int S_FEX = 4;
    localparam int S_TRP = 5;
    localparam int S_ALN = 6;
    localparam int S_DSI = 7;
    localparam int S_SC  = 8;
    localparam int S_TRC = 9;
    localparam int S_AST = 10;

    typedef enum logic [3:0] {
        C_NONE, C_RESET, C_MCHECK, C_DSTORE, C_ISTORE, C_EXTERN, C_ALIGN,
        C_PROGRAM, C_FPUNAV, C_DECR, C_SYSCALL, C_TRACE, C_FPASST
    } exd_cause_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic        fetch_fault;
        logic        illegal_op;
        logic        privileged;
        logic        spr_invalid_hi;
        logic        trap_hit;
        logic        float_op;
        logic        float_enabled_summary;
        logic        data_fault;
        logic        misaligned;
        logic        system_call_instr;
        logic        branch;
        logic        float_assist;
    } exd_cmp_t;

endpackage : exd_pkg

// ==== verification/exd_pin_src.sv ====
// Model of the request pins that sit outside the core: reset, machine check
// and external interrupt sources plus the state-lost indication.
// Assumes the bench calls its tasks; pins move at no fixed phase to the clock.
`timescale 1ns/1ps
module exd_pin_src (
    input  wire logic i_clk,
    output logic      o_reset_req,
    output logic      o_mcheck_req,
    output logic      o_ext_req,
    output logic      o_state_lost
);
    initial begin
        o_reset_req  = 1'b0;
        o_mcheck_req = 1'b0;
        o_ext_req    = 1'b0;
        o_state_lost = 1'b0;
    end

    // Pulses last four cycles so that the two-flop synchroniser sees them.
    task automatic pulse(input bit mc, input bit lost);
        @(posedge i_clk);
        #13;
        o_state_lost = lost;
        if (mc) o_mcheck_req = 1'b1;
        else o_reset_req = 1'b1;
        repeat (4) @(posedge i_clk);
        #7;
        o_mcheck_req = 1'b0;
        o_reset_req  = 1'b0;
        repeat (8) @(posedge i_clk);
        o_state_lost = 1'b0;
    endtask : pulse

    task automatic level(input bit on);
        @(posedge i_clk);
        #11;
        o_ext_req = on;
    endtask : level
endmodule : exd_pin_src

// ==== verification/tb.sv ====
// Self-checking bench for the exception dispatch unit.
// Assumes the pin model above and the register map of the package.
`timescale 1ns/1ps
module tb;
    import exd_pkg::*;
    localparam logic [31:0] PC  = 32'h0000_1000;
    localparam logic [31:0] NPC = 32'h0000_1004;
    logic        i_clk, i_rst, i_cmp_valid, i_exec_busy, i_dec_msb;
    logic        i_wr, i_rd, rst_p, mc_p, ext_p, lost_p;
    exd_cmp_t    i_cmp;
    logic [31:0] i_next_pc, i_wdata, o_rdata, o_vector, d;
    logic [3:0]  i_addr;
    logic        o_cmp_ready, o_take, o_checkstop;
    exd_cause_t  o_cause;
    logic [35:0] takes[$];
    int          n_fail, checks_done;

    exd_pin_src src_u (.i_clk(i_clk), .o_reset_req(rst_p),
        .o_mcheck_req(mc_p), .o_ext_req(ext_p), .o_state_lost(lost_p));
    exd_dispatch dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_cmp_valid(i_cmp_valid), .i_cmp(i_cmp), .o_cmp_ready(o_cmp_ready),
        .i_exec_busy(i_exec_busy), .i_next_pc(i_next_pc),
        .i_dec_msb(i_dec_msb), .i_reset_req(rst_p), .i_mcheck_req(mc_p),
        .i_ext_req(ext_p), .i_state_lost(lost_p), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_take(o_take), .o_vector(o_vector), .o_cause(o_cause),
        .o_checkstop(o_checkstop));

    always #20 i_clk = ~i_clk;

    always @(negedge i_clk) begin
        if (o_take === 1'b1) takes.push_back({o_cause, o_vector});
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd

    // Holds the report until the unit retires it, as the completion stage does.
    task automatic issue(input logic [11:0] f);
        int n;
        @(posedge i_clk);
        i_cmp_valid <= 1'b1;
        i_cmp <= {PC, NPC, f};
        n = 0;
        #1;
        while (o_cmp_ready !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 40) n_fail++;
        @(posedge i_clk);
        i_cmp_valid <= 1'b0;
    endtask : issue

    task automatic expect_take(input exd_cause_t c, input logic [31:0] v);
        int n;
        logic [35:0] e;
        n = 0;
        while (takes.size() == 0 && n < 40) begin
            @(posedge i_clk);
            n++;
        end
        e = (takes.size() != 0) ? takes.pop_front() : 36'hf_ffff_ffff;
        chk({28'h0, e[35:32]}, {28'h0, c});
        chk(e[31:0], v);
    endtask : expect_take

    task automatic no_take(input int n);
        repeat (n) @(posedge i_clk);
        chk(32'(takes.size()), 32'h0);
    endtask : no_take

    task automatic run_case(input logic [31:0] m, input logic [11:0] f,
                            input exd_cause_t c, input logic [19:0] o,
                            input logic [31:0] r);
        logic [31:0] v;
        v = {12'h0, o} | (m[MSW_IP] ? VEC_HIGH_BASE : 32'h0);
        wr(REG_MSW, m);
        issue(f);
        if (c == C_NONE) no_take(5);
        else begin
            expect_take(c, v);
            rd(REG_RAS, d);
            chk(d, r);
            rd(REG_MSW, d);
            chk({31'h0, d[MSW_PR]}, 32'h0);
        end
    endtask : run_case

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        {i_clk, i_cmp_valid, i_exec_busy, i_dec_msb, i_wr, i_rd} = '0;
        {i_cmp, i_wdata, i_addr, n_fail, checks_done} = '0;
        i_rst = 1'b1;
        i_next_pc = 32'h0000_2468;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(REG_MSW, d);
        chk(d, MSW_RST);
        rd(4'h2, d);
        chk(d, 32'h0);
        run_case(32'h10, 12'h800, C_ISTORE, OFF_ISTORE, PC);
        run_case(32'h10, 12'h400, C_PROGRAM, OFF_PROGRAM, PC);
        run_case(32'h14, 12'h200, C_PROGRAM, OFF_PROGRAM, PC);
        run_case(32'h10, 12'h200, C_NONE, OFF_PROGRAM, PC);
        run_case(32'h14, 12'h100, C_PROGRAM, OFF_PROGRAM, PC);
        run_case(32'h10, 12'h080, C_PROGRAM, OFF_PROGRAM, PC);
        run_case(32'h10, 12'h040, C_FPUNAV, OFF_FPUNAV, PC);
        run_case(32'h18, 12'h040, C_NONE, OFF_FPUNAV, PC);
        run_case(32'h110, 12'h020, C_PROGRAM, OFF_PROGRAM, PC);
        run_case(32'h10, 12'h020, C_NONE, OFF_PROGRAM, PC);
        run_case(32'h10, 12'h010, C_DSTORE, OFF_DSTORE, PC);
        run_case(32'h10, 12'h008, C_ALIGN, OFF_ALIGN, PC);
        run_case(32'h10, 12'h004, C_SYSCALL, OFF_SYSCALL, NPC);
        run_case(32'h30, 12'h000, C_TRACE, OFF_TRACE, NPC);
        run_case(32'h50, 12'h002, C_TRACE, OFF_TRACE, NPC);
        run_case(32'h50, 12'h000, C_NONE, OFF_TRACE, NPC);
        run_case(32'h10, 12'h001, C_FPASST, OFF_FPASST, PC);
        run_case(32'h90, 12'h400, C_PROGRAM, OFF_PROGRAM, PC);
        // Two conditions of one instruction arrive as two separate takes.
        wr(REG_MSW, 32'h10);
        issue(12'h404);
        expect_take(C_PROGRAM, 32'h700);
        expect_take(C_SYSCALL, 32'hc00);
        rd(REG_RAS, d);
        chk(d, NPC);
        // External request waits for enable, then for the execute drain.
        src_u.level(1'b1);
        no_take(10);
        i_exec_busy <= 1'b1;
        wr(REG_MSW, 32'h12);
        no_take(10);
        i_exec_busy <= 1'b0;
        expect_take(C_EXTERN, 32'h500);
        rd(REG_RAS, d);
        chk(d, i_next_pc);
        src_u.level(1'b0);
        // Decrementer edge stays pending while disabled, taken once enabled.
        @(posedge i_clk);
        i_dec_msb <= 1'b1;
        no_take(10);
        i_dec_msb <= 1'b0;
        wr(REG_MSW, 32'h12);
        expect_take(C_DECR, 32'h900);
        rd(REG_RAS, d);
        chk(d, i_next_pc);
        no_take(10);
        // Machine check enabled, then disabled into checkstop, then reset.
        wr(REG_MSW, 32'h11);
        src_u.pulse(1'b1, 1'b0);
        expect_take(C_MCHECK, 32'h200);
        rd(REG_SMS, d);
        chk({31'h0, d[MSW_RI]}, 32'h1);
        wr(REG_MSW, 32'h01);
        src_u.pulse(1'b1, 1'b0);
        no_take(5);
        chk({31'h0, o_checkstop}, 32'h1);
        src_u.pulse(1'b0, 1'b1);
        expect_take(C_RESET, 32'h100);
        chk({31'h0, o_checkstop}, 32'h0);
        rd(REG_SMS, d);
        chk({31'h0, d[MSW_RI]}, 32'h0);
        tally_and_finish;
    end
endmodule : tb
